// *** core/osc_select_pll_translate.sv ***
/*
 * Oscillator select and crystal-to-PLL translation, top level with an
 * Avalon-MM slave holding the run-mode clock config and translation words.
 * Assumes a single 40 MHz ref_clk and a master that holds its request
 * until waitrequest is seen low.
 */
// Contract
// - source code 0 main, 1 internal, 2 internal/4, 3 30 kHz, reset 1.
// - internal oscillator runs while its disable bit is 0, reset 0.
// - main oscillator runs while its disable bit is 0, reset 1.
// - translation word is loaded for the current crystal code at reset.
// - translation word follows any new crystal code written.
// - pll frequency is oscillator times multiplier over divider plus one.
// - multiplier is read-only bits 13:5 of the translation word.
// - divider is read-only bits 4:0 of the translation word.
// - translation word sits at offset 0x064 and ignores writes.
// - bits 3:2 of the run-mode clock config read zero.
// - crystal code lives in bits 9:6 and resets to 0xB.
// - bypass set drives the system clock from the oscillator, else the pll.
`timescale 1ns/100ps
module osc_select_pll_translate
   import osc_pll_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,
   output logic main_osc_enable,
   output logic internal_osc_enable,
   output logic [NUM_SRC-1:0] osc_sel_onehot,
   output logic sysclk_from_osc,
   output logic sysclk_from_pll,
   output logic [8:0] pll_mult,
   output logic [4:0] pll_div,
   output logic pll_xlate_update
);

   bus_state_e state;
   bus_state_e next_state;

   logic main_osc_disable;
   logic internal_osc_disable;
   logic [1:0] osc_src;
   logic [3:0] crystal_frequency_code;
   logic pll_bypass;

   // address decode
   wire hit_run = (address == RUN_CLK_OFS);
   wire hit_pll = (address == PLL_XLATE_OFS);
   wire req = read | write;

   // one wait cycle per access: read data settle in a flop first
   assign waitrequest = req & (state == BUS_IDLE);
   wire commit = req & (state == BUS_ANSWER);
   wire wr_run = commit & write & hit_run;

   // assembled run-mode clock config word
   logic [DATA_W-1:0] run_clock_config;
   always_comb begin
      run_clock_config = '0;
      run_clock_config[MAIN_OSCILLATOR_DIS_BIT] = main_osc_disable;
      run_clock_config[INTERNAL_OSCILLATOR_DIS_BIT] = internal_osc_disable;
      run_clock_config[OSCSRC_LSB +: OSCSRC_W] = osc_src;
      run_clock_config[CRYSTAL_FREQUENCY_CODE_LSB +: CRYSTAL_FREQUENCY_CODE_W] = crystal_frequency_code;
      run_clock_config[BYPASS_BIT] = pll_bypass;
   end

   logic [DATA_W-1:0] pll_translation_value;
   always_comb begin
      pll_translation_value = '0;
      pll_translation_value[PLL_F_LSB +: PLL_F_W] = pll_mult;
      pll_translation_value[PLL_R_LSB +: PLL_R_W] = pll_div;
   end

   // unmapped addresses read zero and swallow writes
   wire [DATA_W-1:0] read_word = hit_run ? run_clock_config :
                                 hit_pll ? pll_translation_value : '0;

   // byte-lane merge for writes
   logic [DATA_W-1:0] lane_mask;
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign lane_mask[b*8 +: 8] = {8{byteenable[b]}};
      end
   endgenerate
   wire [DATA_W-1:0] merged = (run_clock_config & ~lane_mask) | (writedata & lane_mask);

   always_comb begin
      next_state = state;
      case (state)
         BUS_IDLE: begin
            if (req) begin
               next_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            next_state = BUS_IDLE;
         end
         default: begin
            next_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BUS_IDLE;
         readdata <= '0;
      end else begin
         state <= next_state;
         if (waitrequest && read) begin
            readdata <= read_word;
         end
      end
   end

   // writable fields only; reserved bits have no storage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_osc_disable <= MAIN_OSCILLATOR_DIS_RST;
         internal_osc_disable <= INTERNAL_OSCILLATOR_DIS_RST;
         osc_src <= OSCSRC_RST;
         crystal_frequency_code <= CRYSTAL_FREQUENCY_CODE_RST;
         pll_bypass <= BYPASS_RST;
      end else if (wr_run) begin
         main_osc_disable <= merged[MAIN_OSCILLATOR_DIS_BIT];
         internal_osc_disable <= merged[INTERNAL_OSCILLATOR_DIS_BIT];
         osc_src <= merged[OSCSRC_LSB +: OSCSRC_W];
         crystal_frequency_code <= merged[CRYSTAL_FREQUENCY_CODE_LSB +: CRYSTAL_FREQUENCY_CODE_W];
         pll_bypass <= merged[BYPASS_BIT];
      end
   end

   osc_source_decode u_decode (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .osc_src(osc_src),
      .internal_osc_disable(internal_osc_disable),
      .main_osc_disable(main_osc_disable),
      .pll_bypass(pll_bypass),
      .main_osc_enable(main_osc_enable),
      .internal_osc_enable(internal_osc_enable),
      .osc_sel_onehot(osc_sel_onehot),
      .sysclk_from_osc(sysclk_from_osc),
      .sysclk_from_pll(sysclk_from_pll)
   );

   crystal_pll_lookup u_lookup (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .crystal_frequency_code(crystal_frequency_code),
      .pll_mult(pll_mult),
      .pll_div(pll_div),
      .pll_xlate_update(pll_xlate_update)
   );

endmodule : osc_select_pll_translate

// *** core/osc_pll_pkg.sv ***
/*
 * Constants for the oscillator select and crystal-to-PLL translation block:
 * register offsets, field positions, reset values, source codes, bus states
 * and the crystal lookup table.
 * Assumes a 32-bit register bus with byte addresses and one word per register.
 */
package osc_pll_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // byte offsets
   localparam logic [7:0] RUN_CLK_OFS = 8'h60;
   localparam logic [7:0] PLL_XLATE_OFS = 8'h64;

   // run-mode clock config field positions
   localparam int MAIN_OSCILLATOR_DIS_BIT = 0;
   localparam int INTERNAL_OSCILLATOR_DIS_BIT = 1;
   localparam int OSCSRC_LSB = 4;
   localparam int OSCSRC_W = 2;
   localparam int CRYSTAL_FREQUENCY_CODE_LSB = 6;
   localparam int CRYSTAL_FREQUENCY_CODE_W = 4;
   localparam int BYPASS_BIT = 11;

   // translation register field positions
   localparam int PLL_R_LSB = 0;
   localparam int PLL_R_W = 5;
   localparam int PLL_F_LSB = 5;
   localparam int PLL_F_W = 9;

   // reset values
   localparam logic MAIN_OSCILLATOR_DIS_RST = 1'b1;
   localparam logic INTERNAL_OSCILLATOR_DIS_RST = 1'b0;
   localparam logic [1:0] OSCSRC_RST = 2'h1;
   localparam logic [3:0] CRYSTAL_FREQUENCY_CODE_RST = 4'hB;
   localparam logic BYPASS_RST = 1'b1;

   typedef enum logic [1:0] {
      SRC_MAIN = 2'h0,
      SRC_INT = 2'h1,
      SRC_INT_DIV4 = 2'h2,
      SRC_LOW_30K = 2'h3
   } osc_src_e;

   localparam int NUM_SRC = 4;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_e;

   // multiplier and divider per crystal code, aiming at about 400 MHz
   localparam logic [8:0] F_TABLE [0:15] = '{
      9'h190, 9'h1B2, 9'h190, 9'h1E8, 9'h14F, 9'h146, 9'h190, 9'h187,
      9'h197, 9'h190, 9'h187, 9'h190, 9'h187, 9'h146, 9'h190, 9'h187
   };
   localparam logic [4:0] R_TABLE [0:15] = '{
      5'h00, 5'h01, 5'h01, 5'h02, 5'h02, 5'h02, 5'h03, 5'h03,
      5'h04, 5'h04, 5'h04, 5'h05, 5'h05, 5'h05, 5'h07, 5'h07
   };

endpackage : osc_pll_pkg

// *** core/osc_source_decode.sv ***
/*
 * Oscillator source decode: turns the source code and the two disable bits
 * into registered enables and a one-hot source select, plus bypass steering.
 * Assumes the clock muxes themselves sit outside and glitch-free.
 */
`timescale 1ns/100ps
module osc_source_decode
   import osc_pll_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [1:0] osc_src,
   input wire logic internal_osc_disable,
   input wire logic main_osc_disable,
   input wire logic pll_bypass,
   output logic main_osc_enable,
   output logic internal_osc_enable,
   output logic [NUM_SRC-1:0] osc_sel_onehot,
   output logic sysclk_from_osc,
   output logic sysclk_from_pll
);

   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i++) begin : g_sel
         wire hit = (osc_src == 2'(i));
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               osc_sel_onehot[i] <= (2'(i) == OSCSRC_RST);
            end else begin
               osc_sel_onehot[i] <= hit;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_osc_enable <= ~MAIN_OSCILLATOR_DIS_RST;
         internal_osc_enable <= ~INTERNAL_OSCILLATOR_DIS_RST;
         sysclk_from_osc <= BYPASS_RST;
         sysclk_from_pll <= ~BYPASS_RST;
      end else begin
         main_osc_enable <= ~main_osc_disable;
         internal_osc_enable <= ~internal_osc_disable;
         sysclk_from_osc <= pll_bypass;
         sysclk_from_pll <= ~pll_bypass;
      end
   end

endmodule : osc_source_decode

// *** core/crystal_pll_lookup.sv ***
/*
 * Crystal-to-PLL translation: fixed lookup of multiplier and divider by
 * crystal code, held in flip-flops and refreshed one cycle after a change.
 * Assumes the code input is a register on the same clock.
 */
`timescale 1ns/100ps
module crystal_pll_lookup
   import osc_pll_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] crystal_frequency_code,
   output logic [8:0] pll_mult,
   output logic [4:0] pll_div,
   output logic pll_xlate_update
);

   logic [3:0] last_code;
   // pll out = osc * mult / (div + 1)
   wire [8:0] next_mult = F_TABLE[crystal_frequency_code];
   wire [4:0] next_div = R_TABLE[crystal_frequency_code];
   wire code_changed = (crystal_frequency_code != last_code);

   // reset loads the entry of the reset crystal code
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_mult <= F_TABLE[CRYSTAL_FREQUENCY_CODE_RST];
         pll_div <= R_TABLE[CRYSTAL_FREQUENCY_CODE_RST];
         last_code <= CRYSTAL_FREQUENCY_CODE_RST;
         pll_xlate_update <= 1'b0;
      end else begin
         pll_mult <= next_mult;
         pll_div <= next_div;
         last_code <= crystal_frequency_code;
         pll_xlate_update <= code_changed;
      end
   end

endmodule : crystal_pll_lookup

// *** tb/osc_select_pll_translate_props.sv ***
/*
 * Checker for the oscillator select and translation top level.
 * Assumes one clock and that reads stay apart from a just-written code.
 */
`timescale 1ns/100ps
module osc_select_pll_translate_props
   import osc_pll_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic main_osc_enable,
   input wire logic internal_osc_enable,
   input wire logic [NUM_SRC-1:0] osc_sel_onehot,
   input wire logic sysclk_from_osc,
   input wire logic sysclk_from_pll,
   input wire logic [8:0] pll_mult,
   input wire logic [4:0] pll_div,
   input wire logic pll_xlate_update
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire rd_ack = read && !waitrequest;
   wire at_xl = address == PLL_XLATE_OFS;
   wire at_rc = address == RUN_CLK_OFS;
   a_one_wait: assert property (($rose(read) || $rose(write)) |-> waitrequest ##1 !waitrequest)
      else $error("wait state count wrong");
   a_idle_free: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest without request");
   a_src_onehot: assert property ($onehot(osc_sel_onehot))
      else $error("source select not one-hot");
   a_bypass_steer: assert property (sysclk_from_osc != sysclk_from_pll)
      else $error("clock steering inconsistent");
   a_rd_xlate: assert property (rd_ack && at_xl |->
      readdata == {18'h0, $past(pll_mult), $past(pll_div)}) else $error("bad translation read");
   a_rd_run: assert property (rd_ack && at_rc |->
      readdata[3:0] == {2'b00, ~internal_osc_enable, ~main_osc_enable}
      && readdata[11] == sysclk_from_osc && osc_sel_onehot[readdata[5:4]])
      else $error("run config read disagrees with outputs");
   a_rd_unmapped: assert property (rd_ack && !at_xl && !at_rc |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_upd_pulse: assert property (
      pll_xlate_update == ($changed(pll_mult) || $changed(pll_div)))
      else $error("update pulse misplaced");
   a_ro_write: assert property (write && !waitrequest && at_xl |->
      ##2 ($stable(pll_mult) && $stable(pll_div))) else $error("translation word written");
endmodule : osc_select_pll_translate_props

bind osc_select_pll_translate osc_select_pll_translate_props u_props (.ref_clk(ref_clk),
   .rst_n(rst_n), .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .main_osc_enable(main_osc_enable),
   .internal_osc_enable(internal_osc_enable), .osc_sel_onehot(osc_sel_onehot),
   .sysclk_from_osc(sysclk_from_osc), .sysclk_from_pll(sysclk_from_pll),
   .pll_mult(pll_mult), .pll_div(pll_div), .pll_xlate_update(pll_xlate_update));

// *** tb/osc_select_pll_translate_tb.sv ***
/*
 * Register-level bench: one Avalon-MM bus task for reads and writes, and checks of the
 * outputs. Assumes the package constants and one 40 MHz clock.
 */
`timescale 1ns/100ps
module osc_select_pll_translate_tb
   import osc_pll_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q, w, e;
   logic waitrequest, main_osc_enable, internal_osc_enable, sysclk_from_osc;
   logic sysclk_from_pll, pll_xlate_update;
   logic [3:0] osc_sel_onehot;
   logic [8:0] pll_mult;
   logic [4:0] pll_div;
   int num_errors = 0;
   int compares = 0;
   wire [31:0] outs = {10'h0, pll_mult, pll_div, main_osc_enable, internal_osc_enable,
      sysclk_from_osc, sysclk_from_pll, osc_sel_onehot};

   osc_select_pll_translate u_osc_select_pll_translate (.ref_clk(ref_clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
      .main_osc_enable(main_osc_enable), .internal_osc_enable(internal_osc_enable),
      .osc_sel_onehot(osc_sel_onehot), .sysclk_from_osc(sysclk_from_osc),
      .sysclk_from_pll(sysclk_from_pll), .pll_mult(pll_mult), .pll_div(pll_div),
      .pll_xlate_update(pll_xlate_update));

   initial forever #12.5 ref_clk = ~ref_clk;

   task finish_test;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task cmp(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : cmp

   // trailing idle edge keeps requests apart and lets decode outputs settle
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         num_errors++;
         finish_test;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus(0, RUN_CLK_OFS, 0); cmp(q, 32'h00000AD1);
      bus(0, PLL_XLATE_OFS, 0); cmp(q, 32'h00003205);
      cmp(outs, {10'h0, 9'h190, 5'h05, 4'b0110, 4'b0010});
      $display("test reset values done");
      // reserved bits 31:12 and 3:2 written as ones must read back zero
      for (int c = 0; c < 16; c++) begin
         w = 32'hFFFFF00C | {20'h0, c[0], 1'b0, c[3:0], c[1:0], 2'b00, c[2:1]};
         bus(1, RUN_CLK_OFS, w);
         // every code in the sweep differs from the one before, so the pulse is due
         @(posedge ref_clk);
         cmp({31'h0, pll_xlate_update}, 32'h1);
         bus(0, RUN_CLK_OFS, 0); cmp(q, w & 32'h00000BF3);
         e = {18'h0, F_TABLE[c], R_TABLE[c]};
         bus(0, PLL_XLATE_OFS, 0); cmp(q, e);
         cmp(outs, {10'h0, e[13:0], ~w[0], ~w[1], w[11], ~w[11], 4'b0001 << w[5:4]});
      end
      $display("test crystal codes done");
      bus(1, PLL_XLATE_OFS, 32'h0);
      bus(0, PLL_XLATE_OFS, 0); cmp(q, e);
      bus(0, 8'h80, 0); cmp(q, 32'h0);
      $display("test refused accesses done");
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus(0, PLL_XLATE_OFS, 0); cmp(q, 32'h00003205);
      $display("test second reset done");
      finish_test;
   end
endmodule : osc_select_pll_translate_tb
